// [rtl/zol_cfg.svh]
// offsets, field positions, reset values and steps of the loop controller
`ifndef ZOL_CFG_SVH
`define ZOL_CFG_SVH
`define ZOL_OFF_LOOP_BASE 8'h00
`define ZOL_LOOP_STRIDE   8'h0c
`define ZOL_OFF_CTRL      8'h18
`define ZOL_OFF_STATUS    8'h1c
`define ZOL_CTRL_EN_BIT   0
`define ZOL_STAT_EN_BIT   2
`define ZOL_CTRL_RESET    1'b1
`define ZOL_LOOP_RESET    32'h0000_0000
`define ZOL_INSTR_BYTES   32'h0000_0004
`define ZOL_RESP_OKAY     2'b00
`define ZOL_RESP_SLVERR   2'b10
`define ZOL_RESP_DECERR   2'b11
`endif

// [rtl/zol_ctrl.sv]
// zero-overhead loop controller with a register view over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "zol_cfg.svh"
module zol_ctrl
#(
  parameter int       NUM_LOOPS    = 2,
  parameter int       ADDR_W       = 8,
  parameter bit       ENABLE_LOOPS = 1'b1
)
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   setup_valid,
  input  wire zol_pkg::zol_setup_op_t setup_op,
  input  wire logic                   setup_loop,
  input  wire zol_pkg::zol_word_t     setup_start,
  input  wire zol_pkg::zol_word_t     setup_end,
  input  wire zol_pkg::zol_word_t     setup_count,
  input  wire logic                   ex_valid,
  input  wire logic                   ex_cancel,
  input  wire zol_pkg::zol_word_t     ex_pc,
  input  wire zol_pkg::zol_word_t     fetch_pc_next,
  output var  logic                   redirect_valid,
  output var  zol_pkg::zol_word_t     redirect_pc,
  output var  logic                   epc_valid,
  output var  zol_pkg::zol_word_t     epc_pc,
  output var  logic                   illegal_instr
);
  import zol_pkg::*;

  if (NUM_LOOPS != 2) $error("zol_ctrl serves exactly two loop sets");
  if (ADDR_W < 5) $error("zol_ctrl needs at least five address bits");

  // which register fields a setup instruction writes for one set
  function automatic logic [2:0] setup_wr(input logic v,
                                          input zol_setup_op_t op,
                                          input logic sel,
                                          input logic idx);
    logic [2:0] w;
    w = 3'h0;
    if (v && ENABLE_LOOPS && sel == idx)
    begin
      unique case (op)
        ZOL_SET_START: w = 3'h1;
        ZOL_SET_END:   w = 3'h2;
        ZOL_SET_COUNT: w = 3'h4;
        ZOL_SET_ALL:   w = 3'h7;
      endcase
    end
    return w;
  endfunction

  // register selected by a bus address
  function automatic zol_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    if (a[ADDR_W-1:0] != ADDR_W'(b))
      return ZOL_SEL_NONE;
    unique case (b)
      `ZOL_OFF_LOOP_BASE:                          return ZOL_SEL_START0;
      `ZOL_OFF_LOOP_BASE + 8'h04:                  return ZOL_SEL_END0;
      `ZOL_OFF_LOOP_BASE + 8'h08:                  return ZOL_SEL_COUNT0;
      `ZOL_OFF_LOOP_BASE + `ZOL_LOOP_STRIDE:       return ZOL_SEL_START1;
      `ZOL_OFF_LOOP_BASE + `ZOL_LOOP_STRIDE + 8'h04: return ZOL_SEL_END1;
      `ZOL_OFF_LOOP_BASE + `ZOL_LOOP_STRIDE + 8'h08: return ZOL_SEL_COUNT1;
      `ZOL_OFF_CTRL:                               return ZOL_SEL_CTRL;
      `ZOL_OFF_STATUS:                             return ZOL_SEL_STATUS;
      default:                                     return ZOL_SEL_NONE;
    endcase
  endfunction

  zol_word_t start_q [NUM_LOOPS];
  zol_word_t end_q   [NUM_LOOPS];
  zol_word_t count_q [NUM_LOOPS];
  logic [NUM_LOOPS-1:0] hit;
  logic [NUM_LOOPS-1:0] dec;
  logic [NUM_LOOPS-1:0] fmatch;
  logic                 ctrl_en;

  for (genvar i = 0; i < NUM_LOOPS; i++)
  begin : g_set
    zol_set_if sif ();
    zol_loop_set u_set (.aclk(aclk), .aresetn(aresetn), .port(sif.set));
    assign sif.wr = setup_wr(setup_valid, setup_op, setup_loop,
                             1'(i));
    assign sif.start_val = setup_start;
    assign sif.end_val   = setup_end;
    assign sif.count_val = setup_count;
    assign sif.dec       = dec[i];
    assign start_q[i]    = sif.loop_start;
    assign end_q[i]      = sif.loop_end;
    assign count_q[i]    = sif.loop_count;
    // retire of the last body instruction; a cancelled one is left alone
    // and simply matches again on re-execution or single step
    assign hit[i] = ENABLE_LOOPS && ex_valid && !ex_cancel
                    && ex_pc == end_q[i] - `ZOL_INSTR_BYTES
                    && count_q[i] != 32'h0;
    // fetch loops back only while another pass remains
    assign fmatch[i] = fetch_pc_next == end_q[i] - `ZOL_INSTR_BYTES
                       && count_q[i] > 32'h1;
  end

  // inner loop 0 wins when both ends coincide; no bound checks at all
  assign dec[0] = hit[0];
  assign dec[1] = hit[1] && !hit[0];

  // fetch redirect registered to line up with the next fetch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      redirect_valid <= 1'b0;
      redirect_pc    <= `ZOL_LOOP_RESET;
    end
    else
    begin
      redirect_valid <= ENABLE_LOOPS && ctrl_en
                        && (fmatch[0] || fmatch[1]);
      redirect_pc    <= fmatch[0] ? start_q[0] : start_q[1];
    end
  end

  // cancelled instruction address handed to the exception pc
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      epc_valid <= 1'b0;
      epc_pc    <= `ZOL_LOOP_RESET;
    end
    else
    begin
      epc_valid <= ex_valid && ex_cancel;
      epc_pc    <= (ex_valid && ex_cancel) ? ex_pc : epc_pc;
    end
  end

  // write channel
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic              next_aw_have;
  logic              next_w_have;
  logic              next_bvalid;
  zol_sel_t          wsel;

  assign do_write     = aw_have && w_have && !s_axi_bvalid;
  assign next_aw_have = (aw_have && !do_write)
                        || (s_axi_awvalid && s_axi_awready);
  assign next_w_have  = (w_have && !do_write)
                        || (s_axi_wvalid && s_axi_wready);
  assign next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
  assign wsel         = reg_sel(aw_addr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
    end
    else
    begin
      aw_have       <= next_aw_have;
      w_have        <= next_w_have;
      s_axi_awready <= !next_aw_have && !next_bvalid;
      s_axi_wready  <= !next_w_have && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr <= '0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // loop registers refuse plain writes and flag an illegal instruction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bresp   <= `ZOL_RESP_OKAY;
      illegal_instr <= 1'b0;
    end
    else
    begin
      illegal_instr <= do_write && wsel < ZOL_SEL_CTRL;
      if (do_write)
      begin
        unique case (wsel)
          ZOL_SEL_CTRL: s_axi_bresp <= `ZOL_RESP_OKAY;
          ZOL_SEL_NONE: s_axi_bresp <= `ZOL_RESP_DECERR;
          default:      s_axi_bresp <= `ZOL_RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_en <= `ZOL_CTRL_RESET;
    else if (do_write && wsel == ZOL_SEL_CTRL && w_strb[0])
      ctrl_en <= w_data[`ZOL_CTRL_EN_BIT];
  end

  // read channel, answer one cycle after the address is taken
  zol_sel_t rsel;
  logic     next_rvalid;
  logic     ar_take;
  assign rsel        = reg_sel(s_axi_araddr);
  assign ar_take     = s_axi_arvalid && s_axi_arready;
  assign next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `ZOL_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_take)
      begin
        s_axi_rresp <= `ZOL_RESP_OKAY;
        unique case (rsel)
          ZOL_SEL_START0: s_axi_rdata <= start_q[0];
          ZOL_SEL_END0:   s_axi_rdata <= end_q[0];
          ZOL_SEL_COUNT0: s_axi_rdata <= count_q[0];
          ZOL_SEL_START1: s_axi_rdata <= start_q[1];
          ZOL_SEL_END1:   s_axi_rdata <= end_q[1];
          ZOL_SEL_COUNT1: s_axi_rdata <= count_q[1];
          ZOL_SEL_CTRL:   s_axi_rdata <= {31'h0, ctrl_en};
          ZOL_SEL_STATUS: s_axi_rdata <= {29'h0, ctrl_en,
                                          count_q[1] != 32'h0,
                                          count_q[0] != 32'h0};
          ZOL_SEL_NONE:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ZOL_RESP_DECERR;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_redirect_start: assert property (
    ctrl_en && fmatch[0] |=> redirect_valid && redirect_pc == $past(start_q[0]))
    else $error("loop 0 end did not redirect to its start");
  chk_idle_no_redirect: assert property (
    count_q[0] == 32'h0 && count_q[1] == 32'h0 |=> !redirect_valid)
    else $error("redirect with no active loop");
  chk_retire_decrement: assert property (
    hit[0] && !setup_valid |=> count_q[0] == $past(count_q[0]) - 32'h1)
    else $error("loop 0 count not decremented on retire");
  chk_last_pass_exit: assert property (
    hit[0] && count_q[0] == 32'h1 && !setup_valid
    |=> count_q[0] == 32'h0 ##1 (!redirect_valid || $past(fmatch[1])))
    else $error("last pass did not exit");
  chk_inner_priority: assert property (
    hit[0] && !setup_valid |=> $stable(count_q[1]))
    else $error("outer loop decremented with inner");
  chk_cancel_keeps: assert property (
    ex_valid && ex_cancel && !setup_valid
    |=> epc_valid && epc_pc == $past(ex_pc) && $stable(count_q[0]))
    else $error("cancelled instruction mishandled");
  chk_setup_one_cycle: assert property (
    setup_valid && setup_op == ZOL_SET_ALL && setup_loop
    |=> start_q[1] == $past(setup_start) && end_q[1] == $past(setup_end)
        && count_q[1] == $past(setup_count))
    else $error("combined setup not written in one cycle");
  chk_illegal_write: assert property (
    do_write && wsel < ZOL_SEL_CTRL
    |=> illegal_instr && s_axi_bvalid && s_axi_bresp == `ZOL_RESP_SLVERR)
    else $error("plain write to loop register not refused");
  chk_read_count: assert property (
    ar_take && rsel == ZOL_SEL_COUNT1 && !setup_valid && !hit[1]
    |=> s_axi_rvalid && s_axi_rdata == count_q[1])
    else $error("count read returned wrong value");

  cov_loop_back: cover property (redirect_valid && hit[0]);
  cov_exit: cover property (hit[0] && count_q[0] == 32'h1);
  cov_nested: cover property (hit[1] ##[1:20] redirect_valid);
  cov_illegal: cover property (illegal_instr);
endmodule
`default_nettype wire

// [rtl/zol_loop_set.sv]
// one loop register set: start, end and iteration count flops
`timescale 1ns/1ps
`default_nettype none
`include "zol_cfg.svh"
module zol_loop_set
(
  input wire logic aclk,
  input wire logic aresetn,
  zol_set_if.set   port
);
  import zol_pkg::*;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port.loop_start <= `ZOL_LOOP_RESET;
    else if (port.wr[0])
      port.loop_start <= port.start_val;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port.loop_end <= `ZOL_LOOP_RESET;
    else if (port.wr[1])
      port.loop_end <= port.end_val;
  end

  // a setup write wins over a retire decrement in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port.loop_count <= `ZOL_LOOP_RESET;
    else if (port.wr[2])
      port.loop_count <= port.count_val;
    else if (port.dec)
      port.loop_count <= port.loop_count - 32'h1;
  end
endmodule
`default_nettype wire

// [rtl/zol_pkg.sv]
// types shared by the loop controller files
package zol_pkg;
  typedef logic [31:0] zol_word_t;
  typedef enum logic [1:0] {
    ZOL_SET_START,
    ZOL_SET_END,
    ZOL_SET_COUNT,
    ZOL_SET_ALL
  } zol_setup_op_t;
  typedef enum logic [3:0] {
    ZOL_SEL_START0,
    ZOL_SEL_END0,
    ZOL_SEL_COUNT0,
    ZOL_SEL_START1,
    ZOL_SEL_END1,
    ZOL_SEL_COUNT1,
    ZOL_SEL_CTRL,
    ZOL_SEL_STATUS,
    ZOL_SEL_NONE
  } zol_sel_t;
endpackage

// [rtl/zol_set_if.sv]
// carrier between the controller and one loop register set
`timescale 1ns/1ps
`default_nettype none
interface zol_set_if;
  import zol_pkg::*;
  logic [2:0] wr;
  zol_word_t  start_val;
  zol_word_t  end_val;
  zol_word_t  count_val;
  logic       dec;
  zol_word_t  loop_start;
  zol_word_t  loop_end;
  zol_word_t  loop_count;
  modport ctrl (output wr, start_val, end_val, count_val, dec,
                input loop_start, loop_end, loop_count);
  modport set (input wr, start_val, end_val, count_val, dec,
               output loop_start, loop_end, loop_count);
endinterface
`default_nettype wire

// [test/zol_ctrl_bench.sv]
// self-checking bench for the zero-overhead loop controller
`timescale 1ns/1ps
`default_nettype none
`include "zol_cfg.svh"
module zol_ctrl_bench;
  import zol_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [7:0]    awaddr = 8'h00;
  logic          awvalid = 1'b0;
  logic          awready;
  logic [31:0]   wdata = 32'h0;
  logic [3:0]    wstrb = 4'hf;
  logic          wvalid = 1'b0;
  logic          wready;
  logic [1:0]    bresp;
  logic          bvalid;
  logic          bready = 1'b0;
  logic [7:0]    araddr = 8'h00;
  logic          arvalid = 1'b0;
  logic          arready;
  logic [31:0]   rdata;
  logic [1:0]    rresp;
  logic          rvalid;
  logic          rready = 1'b0;
  logic          setup_valid = 1'b0;
  zol_setup_op_t setup_op = ZOL_SET_START;
  logic          setup_loop = 1'b0;
  zol_word_t     setup_start = 32'h0;
  zol_word_t     setup_end = 32'h0;
  zol_word_t     setup_count = 32'h0;
  logic          ex_valid = 1'b0;
  logic          ex_cancel = 1'b0;
  zol_word_t     ex_pc = 32'h0;
  zol_word_t     fetch_pc = 32'hffff_fff0;
  logic          redirect_valid;
  zol_word_t     redirect_pc;
  logic          epc_valid;
  zol_word_t     epc_pc;
  logic          illegal_instr;
  logic [31:0]   st [2];
  logic [31:0]   en [2];
  logic [31:0]   cn [2];
  logic          ena;
  logic [31:0]   s0;
  logic [31:0]   e0;
  logic [31:0]   pc;
  int            seed;
  int            err_count = 0;
  int            total_checks = 0;

  always #2.5 aclk = ~aclk;

  zol_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .setup_valid(setup_valid), .setup_op(setup_op),
    .setup_loop(setup_loop), .setup_start(setup_start),
    .setup_end(setup_end), .setup_count(setup_count),
    .ex_valid(ex_valid), .ex_cancel(ex_cancel), .ex_pc(ex_pc),
    .fetch_pc_next(fetch_pc), .redirect_valid(redirect_valid),
    .redirect_pc(redirect_pc), .epc_valid(epc_valid), .epc_pc(epc_pc),
    .illegal_instr(illegal_instr));

  task automatic end_of_test;
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic model_reset;
    for (int l = 0; l < 2; l++)
    begin
      st[l] = 32'h0;
      en[l] = 32'h0;
      cn[l] = 32'h0;
    end
    ena = 1'b1;
  endtask

  function automatic logic [31:0] exp_rd(input int i);
    if (i < 6)
      return (i % 3 == 0) ? st[i/3] : (i % 3 == 1) ? en[i/3] : cn[i/3];
    if (i == 6)
      return {31'h0, ena};
    if (i == 7)
      return {29'h0, ena, cn[1] != 0, cn[0] != 0};
    return 32'h0;
  endfunction

  // waits at falling edges, where registered outputs are settled;
  // k picks awready, wready, bvalid, arready or rvalid
  task automatic wait_hi(input int k);
    int         n;
    logic [4:0] v;
    n = 0;
    @(negedge aclk);
    v = {rvalid, arready, bvalid, wready, awready};
    while (v[k] !== 1'b1)
    begin
      n++;
      if (n > 200)
      begin
        err_count++;
        end_of_test();
      end
      @(negedge aclk);
      v = {rvalid, arready, bvalid, wready, awready};
    end
  endtask

  task automatic axi_wr(input int i, input logic [31:0] d,
                        input logic [3:0] s);
    logic        w_ok;
    logic [31:0] eb;
    eb = (i == 6) ? 32'(`ZOL_RESP_OKAY) : (i < 8) ?
         32'(`ZOL_RESP_SLVERR) : 32'(`ZOL_RESP_DECERR);
    @(posedge aclk);
    awaddr <= 8'(i * 4);
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_hi(0);
    w_ok = wready;
    @(posedge aclk);
    awvalid <= 1'b0;
    if (w_ok)
      wvalid <= 1'b0;
    else
    begin
      wait_hi(1);
      @(posedge aclk);
      wvalid <= 1'b0;
    end
    wait_hi(2);
    chk("bresp", 32'(bresp), eb);
    chk("illegal_instr", 32'(illegal_instr), 32'(i < 6));
    @(posedge aclk);
    bready <= 1'b0;
    if (i == 6 && s[0])
      ena = d[0];
  endtask

  task automatic axi_rd(input int i);
    logic [31:0] er;
    er = (i < 8) ? 32'(`ZOL_RESP_OKAY) : 32'(`ZOL_RESP_DECERR);
    @(posedge aclk);
    araddr <= 8'(i * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_hi(3);
    @(posedge aclk);
    arvalid <= 1'b0;
    wait_hi(4);
    chk("rdata", rdata, exp_rd(i));
    chk("rresp", 32'(rresp), er);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic read_all;
    for (int i = 0; i < 9; i++)
      axi_rd(i);
  endtask

  task automatic setup(input zol_setup_op_t op, input int l,
                       input logic [31:0] s, e, c);
    @(posedge aclk);
    setup_valid <= 1'b1;
    setup_op <= op;
    setup_loop <= l[0];
    setup_start <= s;
    setup_end <= e;
    setup_count <= c;
    @(posedge aclk);
    setup_valid <= 1'b0;
    if (op == ZOL_SET_START || op == ZOL_SET_ALL)
      st[l] = s;
    if (op == ZOL_SET_END || op == ZOL_SET_ALL)
      en[l] = e;
    if (op == ZOL_SET_COUNT || op == ZOL_SET_ALL)
      cn[l] = c;
  endtask

  task automatic fetch(input logic [31:0] p);
    logic [31:0] ep;
    logic        ev;
    ev = 1'b1;
    ep = 32'h0;
    if (ena && p == en[0] - 4 && cn[0] > 1)
      ep = st[0];
    else if (ena && p == en[1] - 4 && cn[1] > 1)
      ep = st[1];
    else
      ev = 1'b0;
    @(posedge aclk);
    fetch_pc <= p;
    @(posedge aclk);
    fetch_pc <= 32'hffff_fff0;
    @(negedge aclk);
    chk("redirect_valid", 32'(redirect_valid), 32'(ev));
    if (ev)
      chk("redirect_pc", redirect_pc, ep);
  endtask

  // a retire without cancel also stands for a single-stepped instruction
  task automatic retire(input logic [31:0] p, input logic c);
    @(posedge aclk);
    ex_valid <= 1'b1;
    ex_cancel <= c;
    ex_pc <= p;
    @(posedge aclk);
    ex_valid <= 1'b0;
    ex_cancel <= 1'b0;
    @(negedge aclk);
    chk("epc_valid", 32'(epc_valid), 32'(c));
    if (c)
      chk("epc_pc", epc_pc, p);
    else if (p == en[0] - 4 && cn[0] != 0)
      cn[0]--;
    else if (p == en[1] - 4 && cn[1] != 0)
      cn[1]--;
  endtask

  // an ebreak or ecall on the last instruction traps without retiring;
  // its handler then does the count fix-up through a count setup
  task automatic trap_fixup(input logic [31:0] p);
    int l;
    l = (p == en[0] - 4 && cn[0] != 0) ? 0 : 1;
    retire(p, 1'b1);
    setup(ZOL_SET_COUNT, l, 32'h0, 32'h0, cn[l] - 32'h1);
  endtask

  initial
  begin
    seed = 32'h8edd;
    model_reset();
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    read_all();
    for (int i = 0; i < 10; i++)
      axi_wr(i, $random(seed), 4'hf);
    axi_wr(6, 32'h0, 4'he);
    read_all();
    axi_wr(6, 32'h0, 4'hf);
    s0 = 32'h100 + (32'($random(seed)) & 32'hff0);
    e0 = s0 + 32'hc + ((32'($random(seed)) & 32'h3) << 2);
    setup(ZOL_SET_START, 0, s0, 32'h0, 32'h0);
    setup(ZOL_SET_END, 0, 32'h0, e0, 32'h0);
    setup(ZOL_SET_COUNT, 0, 32'h0, 32'h0,
          32'h2 + (32'($random(seed)) & 32'h3));
    setup(ZOL_SET_ALL, 1, s0 - 4, e0 + 8, 32'h3);
    read_all();
    fetch(e0 - 4);
    axi_wr(6, 32'h1, 4'hf);
    // drain both loops, with random interrupts on the last instruction
    while (cn[0] != 0 || cn[1] != 0)
    begin
      pc = (cn[0] != 0) ? e0 - 4 : e0 + 4;
      fetch(pc);
      if ($random(seed) & 1)
        retire(pc, 1'b1);
      if ($random(seed) & 1)
        trap_fixup(pc);
      else
        retire(pc, 1'b0);
      axi_rd(7);
      axi_rd(2);
    end
    fetch(e0 - 4);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    model_reset();
    read_all();
    end_of_test();
  end
endmodule
`default_nettype wire
